// File: logic/brake_pkg.sv
// package for the holding brake controller: register map, fields, timing
// assumes a 250 MHz system clock and a classic wishbone slave port
package brake_pkg;
   // register byte offsets
   localparam logic [3:0] ADDR_SUBMODE = 4'h0; // drive submode word
   localparam logic [3:0] ADDR_DOUT    = 4'h4; // digital output control word
   localparam logic [3:0] ADDR_TIMING  = 4'h8; // delays 1..4 (ms), 8 bits each
   localparam logic [3:0] ADDR_PWM     = 4'hc; // freq [15:0], duty [23:16]
   // fields
   localparam int SUBMODE_AUTO_BIT = 2;
   localparam int DOUT_BRAKE_BIT   = 0;
   // reset values
   localparam logic [31:0] TIMING_RST = 32'h0000_0000;
   localparam logic [15:0] FREQ_RST   = 16'h03e8; // 1000 Hz
   localparam logic [7:0]  DUTY_RST   = 8'h64;    // 100 percent
   localparam logic [15:0] FREQ_MAX   = 16'h07d0; // 2000 Hz
   localparam logic [7:0]  DUTY_MIN   = 8'h02;
   localparam logic [7:0]  DUTY_MAX   = 8'h64;
   // routing source codes
   localparam logic [7:0] SRC_PWM     = 8'h10;
   localparam logic [7:0] SRC_PWM_INV = 8'h11;
   // timing
   localparam int CLK_HZ      = 250_000_000;
   localparam int MS_US       = 1000;
   localparam int MS_CYCLES   = CLK_HZ / 1_000_000 * MS_US;
   // one pwm step is one percent of a period, per hertz
   localparam int PWM_STEP_HZ = CLK_HZ / 100;

   typedef enum logic [5:0] {
      ST_OFF     = 6'b000001,
      ST_REL_DLY = 6'b000010,
      ST_SETTLE  = 6'b000100,
      ST_RUN     = 6'b001000,
      ST_ENG_DLY = 6'b010000,
      ST_OFF_DLY = 6'b100000
   } seq_t;

   typedef struct packed {
      logic        motor_on;
      logic        brake_rel;
      logic        motion_ok;
   } drive_out_t;
endpackage

// File: logic/brake_ctrl.sv
// holding brake controller: sequencing around operation enabled, brake pwm,
// manual brake mode and one routed output
// assumes a synchronous power state input and wishbone master on clk_i
//
// What this block does
// RL1: automatic handling only in operation enabled
// RL2: released brake output is configurable pwm
// RL3: submode bit 2 set selects automatic
// RL4: bit 2 clear: brake follows output bit 0
// RL5: enable: current, delay 3, release, delay 4
// RL6: disable: stop, delay 1, engage, delay 2, off
// RL7: frequency from subindex 5, max 2000 Hz
// RL8: duty percent from subindex 6, 2..100
// RL9: duty 100 holds output steady on
// RL10: routing code 10h pwm, 11h inverted
// RL11: automatic control uses output bit 0
// RL12: delays counted in ms, zero skips
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module brake_ctrl (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        op_enabled_i,
   input  wire logic        motor_still_i,
   input  wire logic        route_en_i,
   input  wire logic [15:0] route_entry_i,
   output logic             motor_on_o,
   output logic             motion_ok_o,
   output logic             brake_o,
   output logic             route_out_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]          submode;
      logic [31:0]          dout;
      logic [31:0]          timing;
      logic [15:0]          freq;
      logic [7:0]           duty;
      logic [31:0]          dat;
      logic                 ack;
      brake_pkg::seq_t      seq;
      logic [17:0]          ms_cnt;
      logic [7:0]           ms_left;
      logic [31:0]          pwm_acc;
      logic [6:0]           pct;
      logic                 brake;
      logic                 route;
      brake_pkg::drive_out_t drv;
   } state_t;

   state_t s_r, s_nxt;
   logic   req;
   logic   wr_commit;
   logic   route_ctl;
   logic   auto_mode;
   logic   ms_tick;
   logic   delay_done;
   logic   pwm_level;

   assign req       = wb_cyc_i & wb_stb_i & ~s_r.ack;
   // writes commit while ack is up, at the edge where the master samples it
   assign wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack;
   // routing control bit from the output word, optionally inverted
   assign route_ctl = s_r.dout[route_entry_i[4:0]] ^ route_entry_i[7];
   assign auto_mode = s_r.submode[brake_pkg::SUBMODE_AUTO_BIT]; // [RL3]
   assign ms_tick   = (s_r.ms_cnt == 18'(brake_pkg::MS_CYCLES - 1));
   assign delay_done = (s_r.ms_left == 8'h00); // zero delay passes at once [RL12]

   // pwm: phase accumulator steps 100 percent per period at freq hertz [RL2]
   // duty 100 gives a constant high level [RL9]
   assign pwm_level = (s_r.duty >= brake_pkg::DUTY_MAX) ? 1'b1 : (s_r.pct < 7'(s_r.duty));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt     = s_r;
      s_nxt.ack = 1'b0;
      // bus slave, one wait state, unmapped reads give zero
      if (req) begin
         s_nxt.ack = 1'b1;
         s_nxt.dat = 32'h0000_0000;
         case (wb_adr_i)
            brake_pkg::ADDR_SUBMODE: s_nxt.dat = s_r.submode;
            brake_pkg::ADDR_DOUT:    s_nxt.dat = s_r.dout;
            brake_pkg::ADDR_TIMING:  s_nxt.dat = s_r.timing;
            brake_pkg::ADDR_PWM:     s_nxt.dat = {2'b00, s_r.seq, s_r.duty, s_r.freq};
            default:                 s_nxt.dat = 32'h0000_0000;
         endcase
      end
      // a write lands while the master still holds address and data; ack
      // stands for one cycle only, so each request commits exactly once
      if (wr_commit) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               case (wb_adr_i)
                  brake_pkg::ADDR_SUBMODE: s_nxt.submode[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                  brake_pkg::ADDR_DOUT:    s_nxt.dout[b*8 +: 8]    = wb_dat_i[b*8 +: 8];
                  brake_pkg::ADDR_TIMING:  s_nxt.timing[b*8 +: 8]  = wb_dat_i[b*8 +: 8];
                  default: ;
               endcase
            end
         end
         // out of range settings are refused whole [RL7] [RL8]
         if (wb_adr_i == brake_pkg::ADDR_PWM && (&wb_sel_i[1:0])
             && wb_dat_i[15:0] <= brake_pkg::FREQ_MAX && wb_dat_i[15:0] != 16'h0000)
            s_nxt.freq = wb_dat_i[15:0];
         if (wb_adr_i == brake_pkg::ADDR_PWM && wb_sel_i[2]
             && wb_dat_i[23:16] >= brake_pkg::DUTY_MIN
             && wb_dat_i[23:16] <= brake_pkg::DUTY_MAX)
            s_nxt.duty = wb_dat_i[23:16];
      end

      // pwm accumulator
      if (s_r.pwm_acc + 32'(s_r.freq) >= 32'(brake_pkg::PWM_STEP_HZ)) begin
         s_nxt.pwm_acc = s_r.pwm_acc + 32'(s_r.freq) - 32'(brake_pkg::PWM_STEP_HZ);
         s_nxt.pct     = (s_r.pct == 7'd99) ? 7'd0 : s_r.pct + 7'd1;
      end else begin
         s_nxt.pwm_acc = s_r.pwm_acc + 32'(s_r.freq);
      end

      // millisecond divider runs only while a delay is pending
      // so every delay starts on a fresh millisecond boundary
      s_nxt.ms_cnt = (ms_tick || delay_done) ? 18'h0 : s_r.ms_cnt + 18'h1;
      if (ms_tick && !delay_done)
         s_nxt.ms_left = s_r.ms_left - 8'h01; // [RL12]

      // sequencer, automatic mode only; manual mode parks in off
      case (s_r.seq)
         brake_pkg::ST_OFF: begin
            s_nxt.drv = '0;
            if (auto_mode && op_enabled_i) begin // [RL1]
               s_nxt.drv.motor_on = 1'b1;        // [RL5]
               s_nxt.ms_left      = s_r.timing[23:16];
               s_nxt.ms_cnt       = 18'h0;
               s_nxt.seq          = brake_pkg::ST_REL_DLY;
            end
         end
         brake_pkg::ST_REL_DLY: begin
            if (!op_enabled_i || !auto_mode) begin
               s_nxt.ms_left = s_r.timing[15:8];
               s_nxt.ms_cnt  = 18'h0;
               s_nxt.seq     = brake_pkg::ST_OFF_DLY;
            end else if (delay_done) begin
               s_nxt.drv.brake_rel = 1'b1;       // [RL5]
               s_nxt.ms_left       = s_r.timing[31:24];
               s_nxt.ms_cnt        = 18'h0;
               s_nxt.seq           = brake_pkg::ST_SETTLE;
            end
         end
         brake_pkg::ST_SETTLE: begin
            if (!op_enabled_i || !auto_mode) begin
               s_nxt.ms_left = s_r.timing[7:0];
               s_nxt.ms_cnt  = 18'h0;
               s_nxt.seq     = brake_pkg::ST_ENG_DLY;
            end else if (delay_done) begin
               s_nxt.drv.motion_ok = 1'b1;       // [RL5]
               s_nxt.seq           = brake_pkg::ST_RUN;
            end
         end
         brake_pkg::ST_RUN: begin
            if (!op_enabled_i || !auto_mode) begin
               s_nxt.drv.motion_ok = 1'b0;       // bring motor to rest [RL6]
               if (motor_still_i) begin
                  s_nxt.ms_left = s_r.timing[7:0];
                  s_nxt.ms_cnt  = 18'h0;
                  s_nxt.seq     = brake_pkg::ST_ENG_DLY;
               end
            end
         end
         brake_pkg::ST_ENG_DLY: begin
            s_nxt.drv.motion_ok = 1'b0;
            if (delay_done) begin
               s_nxt.drv.brake_rel = 1'b0;       // [RL6]
               s_nxt.ms_left       = s_r.timing[15:8];
               s_nxt.ms_cnt        = 18'h0;
               s_nxt.seq           = brake_pkg::ST_OFF_DLY;
            end
         end
         brake_pkg::ST_OFF_DLY: begin
            s_nxt.drv.brake_rel = 1'b0;
            if (delay_done) begin
               s_nxt.drv.motor_on = 1'b0;        // [RL6]
               s_nxt.seq          = brake_pkg::ST_OFF;
            end
         end
         default: begin
            s_nxt.drv = '0;
            s_nxt.seq = brake_pkg::ST_OFF;
         end
      endcase

      // brake output: pwm when released, closed otherwise
      // the control bit gates both modes, so software can always shut the brake
      if (auto_mode)
         s_nxt.brake = s_r.drv.brake_rel & pwm_level & s_r.dout[brake_pkg::DOUT_BRAKE_BIT]; // [RL1] [RL11]
      else
         s_nxt.brake = s_r.dout[brake_pkg::DOUT_BRAKE_BIT] & pwm_level; // [RL4]

      // routed output: the pwm generator itself or its inverse, gated by the
      // selected control bit; it does not depend on the brake drive state
      s_nxt.route = 1'b0;
      if (route_en_i && route_entry_i[15:8] == brake_pkg::SRC_PWM)
         s_nxt.route = route_ctl & pwm_level;      // [RL10]
      else if (route_en_i && route_entry_i[15:8] == brake_pkg::SRC_PWM_INV)
         s_nxt.route = route_ctl & ~pwm_level;     // [RL10]
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // sync reset loads constants only; all other state clears to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r         <= '0;
         s_r.timing  <= brake_pkg::TIMING_RST;
         s_r.freq    <= brake_pkg::FREQ_RST;
         s_r.duty    <= brake_pkg::DUTY_RST;
         s_r.seq     <= brake_pkg::ST_OFF;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o    = s_r.dat;
   assign wb_ack_o    = s_r.ack;
   assign motor_on_o  = s_r.drv.motor_on;
   assign motion_ok_o = s_r.drv.motion_ok;
   assign brake_o     = s_r.brake;
   assign route_out_o = s_r.route;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // idle automatic sequencer keeps the brake closed
   a_brake_closed_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
      (auto_mode && !op_enabled_i && s_r.seq == brake_pkg::ST_OFF) |=> !brake_o)
      else $error("brake open outside operation enabled");
   // manual mode: a cleared control bit closes the brake
   a_manual_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
      (!auto_mode && !s_r.dout[0] && !$past(s_r.dout[0])) |=> !brake_o)
      else $error("manual brake not following control bit");
   // release only ever happens with motor current on
   a_release_order: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
      $rose(s_r.drv.brake_rel) |-> s_r.drv.motor_on)
      else $error("brake released without motor current");
   // the release wait runs with current on and the brake still closed
   a_motor_first: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
      (s_r.seq == brake_pkg::ST_REL_DLY) |-> (motor_on_o && !s_r.drv.brake_rel))
      else $error("release wait without current or with brake open");
   a_run_after_rel: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
      $rose(motion_ok_o) |-> s_r.drv.brake_rel)
      else $error("motion allowed while braked");
   // leaving operation enabled withdraws motion at once
   a_motion_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
      (s_r.seq == brake_pkg::ST_RUN && !op_enabled_i) |=> !motion_ok_o)
      else $error("motion still allowed after leaving operation enabled");
   a_off_after_engage: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
      $fell(motor_on_o) |-> !s_r.drv.brake_rel)
      else $error("current off before brake engaged");
   a_freq_limit: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
      s_r.freq <= brake_pkg::FREQ_MAX)
      else $error("pwm frequency above limit");
   a_duty_range: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
      s_r.duty >= brake_pkg::DUTY_MIN && s_r.duty <= brake_pkg::DUTY_MAX)
      else $error("duty out of range");
   // full duty gives a steady drive, seen on the output pin itself
   a_full_duty: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9]
      (!auto_mode && s_r.duty == brake_pkg::DUTY_MAX
       && s_r.dout[brake_pkg::DOUT_BRAKE_BIT]) |=> brake_o)
      else $error("duty 100 not steady");
   // routing switched off leaves the routed output low
   a_route_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
      !route_en_i |=> !route_out_o)
      else $error("routed output active with routing off");
   // automatic mode: a cleared control bit keeps the brake shut
   a_auto_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RL11]
      (auto_mode && !s_r.dout[brake_pkg::DOUT_BRAKE_BIT]) |=> !brake_o)
      else $error("automatic brake open with control bit clear");
   a_zero_delay: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
      (s_r.seq == brake_pkg::ST_REL_DLY && op_enabled_i && auto_mode && delay_done)
      |=> s_r.seq == brake_pkg::ST_SETTLE)
      else $error("finished delay did not advance");
   // the divider rests at zero whenever no delay is pending
   a_ms_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
      delay_done |=> s_r.ms_cnt == 18'h0)
      else $error("millisecond divider running with no delay");
   // a pending engage delay only moves on a millisecond tick
   a_ms_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
      (!ms_tick && !delay_done && s_r.seq == brake_pkg::ST_ENG_DLY)
      |=> s_r.ms_left == $past(s_r.ms_left))
      else $error("delay count moved between ticks");
endmodule
`default_nettype wire

// File: test/brake_model.sv
// external holding brake: coil energised while the drive line is high
// assumes the drive line is sampled on the system clock of the controller
`timescale 1ns/1ps
`default_nettype none
module brake_model #(
   parameter int DECAY = 8
) (
   input  wire logic clk_i,
   input  wire logic drive_i,
   output logic      released_o
);
   // ---------------------------------------------------------------
   // coil
   // ---------------------------------------------------------------
   int unsigned low_cnt = 0;
   logic        rel_r   = 1'b0;
   assign released_o = rel_r;
   // coil current decays slowly, so a short pwm low phase keeps it open
   always @(posedge clk_i) begin
      if (drive_i) begin
         low_cnt <= 0;
         rel_r   <= 1'b1;
      end else if (low_cnt < DECAY) begin
         low_cnt <= low_cnt + 1;
      end else begin
         rel_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: test/tb_brake_ctrl.sv
// testbench for the holding brake controller: registers, sequencing, routing, pwm
// assumes zero brake delays, so every sequence step takes a few cycles only
`timescale 1ns/1ps
`default_nettype none
module tb_brake_ctrl;
   typedef struct packed {
      logic [3:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
      logic [31:0] exp;
   } row_t;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic        ack, op_en = 1'b0, still = 1'b1, rt_en = 1'b0;
   logic [15:0] rt = 16'h0;
   logic        motor_on, motion_ok, brake, rt_out, released, seen_lo, seen_hi;
   int          err_count = 0, n_checks = 0;
   // write with readback; sel 0 rows only read the reset value
   row_t rows [11] = '{
      '{4'hc, 4'h0, 32'h0, 32'h0164_03e8}, '{4'hc, 4'hf, 32'h0032_07d0, 32'h0132_07d0},
      '{4'hc, 4'h3, 32'h0000_07d1, 32'h0132_07d0}, '{4'hc, 4'h3, 32'h0, 32'h0132_07d0},
      '{4'hc, 4'h4, 32'h0001_0000, 32'h0132_07d0}, '{4'hc, 4'h4, 32'h0065_0000, 32'h0132_07d0},
      '{4'hc, 4'h4, 32'h0002_0000, 32'h0102_07d0}, '{4'hc, 4'h4, 32'h0064_0000, 32'h0164_07d0},
      '{4'h8, 4'hf, 32'h0403_0201, 32'h0403_0201}, '{4'h8, 4'hf, 32'h0, 32'h0},
      '{4'h2, 4'hf, 32'hffff_ffff, 32'h0}};
   logic [17:0] rtab [4] = '{{16'h1000, 2'b11}, {16'h1100, 2'b10}, {16'h1080, 2'b01},
                             {16'h1000, 2'b00}};
   brake_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .op_enabled_i(op_en), .motor_still_i(still), .route_en_i(rt_en), .route_entry_i(rt),
      .motor_on_o(motor_on), .motion_ok_o(motion_ok), .brake_o(brake), .route_out_o(rt_out));
   brake_model model (.clk_i(clk_i), .drive_i(brake), .released_o(released));
   always #2 clk_i = ~clk_i;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // bounded wait; a hang counts as a mismatch and ends the run
   task automatic wait_lvl(ref logic s, input logic v);
      int i;
      for (i = 0; s !== v; i++) begin
         if (i > 200) begin
            err_count++;
            print_verdict();
         end
         @(posedge clk_i);
      end
   endtask
   // one classic cycle, held until ack is sampled; read data taken at that edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      @(posedge clk_i);
      wait_lvl(ack, 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      cycles(10);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].adr, rows[i].sel, rows[i].dat);
         bus(1'b0, rows[i].adr, 4'hf, 32'h0);
         check("readback", rdat, rows[i].exp);
      end
      // manual mode, duty 100 gives a steady on output
      bus(1'b1, 4'h4, 4'hf, 32'h1);
      cycles(4);
      check("manual brake", brake, 1'b1);
      check("manual motor", motor_on, 1'b0);
      check("coil", released, 1'b1);
      rt_en <= 1'b1;
      foreach (rtab[i]) begin
         rt <= rtab[i][17:2];
         bus(1'b1, 4'h4, 4'hf, {31'h0, rtab[i][1]});
         cycles(3);
         check("route", rt_out, rtab[i][0]);
      end
      cycles(12);
      check("manual off", brake, 1'b0);
      check("coil off", released, 1'b0);
      // automatic mode: closed until operation enabled
      bus(1'b1, 4'h0, 4'hf, 32'h4);
      bus(1'b1, 4'h4, 4'hf, 32'h1);
      cycles(5);
      check("auto idle", brake, 1'b0);
      op_en <= 1'b1;
      wait_lvl(motor_on, 1'b1);
      check("release after current", brake, 1'b0);
      wait_lvl(motion_ok, 1'b1);
      check("auto released", brake, 1'b1);
      seen_lo = 1'b0;
      repeat (40) begin
         @(posedge clk_i);
         seen_lo |= !brake;
      end
      check("steady", seen_lo, 1'b0);
      bus(1'b1, 4'h4, 4'hf, 32'h0);
      cycles(3);
      check("control bit", brake, 1'b0);
      bus(1'b1, 4'h4, 4'hf, 32'h1);
      cycles(3);
      // leaving: brake held until standstill
      still <= 1'b0;
      op_en <= 1'b0;
      wait_lvl(motion_ok, 1'b0);
      cycles(20);
      check("not still brake", brake, 1'b1);
      check("not still motor", motor_on, 1'b1);
      still <= 1'b1;
      wait_lvl(brake, 1'b0);
      wait_lvl(motor_on, 1'b0);
      check("engaged", brake, 1'b0);
      // reset in mid-run
      op_en <= 1'b1;
      wait_lvl(motion_ok, 1'b1);
      rst_i <= 1'b1;
      op_en <= 1'b0;
      cycles(2);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("reset outputs", {motor_on, motion_ok, brake}, 3'b000);
      bus(1'b0, 4'hc, 4'hf, 32'h0);
      check("reset pwm", rdat, 32'h0164_03e8);
      // 2000 Hz, 50 percent: each phase lasts 62500 cycles
      bus(1'b1, 4'hc, 4'hf, 32'h0032_07d0);
      bus(1'b1, 4'h4, 4'hf, 32'h1);
      seen_lo = 1'b0;
      seen_hi = 1'b0;
      repeat (65000) begin
         @(posedge clk_i);
         seen_lo |= (brake === 1'b0);
         seen_hi |= (brake === 1'b1);
      end
      check("pwm", {seen_lo, seen_hi}, 2'b11);
      print_verdict();
   end
endmodule
`default_nettype wire
